/* src/pcm_defines.vh */
// Constants for the clock mode control block: register map,
// field positions, reset values, divider codes and ramp count.
// Included by bare name from every design file of the block.
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH

// Avalon byte offsets of the two registers
`define PCM_OFS_CTRL        4'h0
`define PCM_OFS_STATUS      4'h4

// Control register fields
`define PCM_CTRL_DIV_LO     0
`define PCM_CTRL_DIV_HI     1
`define PCM_CTRL_LEGACY     2
`define PCM_CTRL_RESET      3'h0

// Status register fields
`define PCM_ST_LOCKED       0
`define PCM_ST_RAMP_DONE    1
`define PCM_ST_MODE_LO      2
`define PCM_ST_MODE_HI      3
`define PCM_ST_DIV_LO       4
`define PCM_ST_DIV_HI       5
`define PCM_ST_STOPPED      6
`define PCM_ST_MULT_PWR     7

// Divider settings written by the CPU
`define PCM_DIV_FULL        2'h0
`define PCM_DIV_SIXTEENTH   2'h1
`define PCM_DIV_STOP        2'h2

// Mode pin codes {high, low}
`define PCM_MODE_STATIC     2'h0
`define PCM_MODE_FULL       2'h1
`define PCM_MODE_HALF       2'h2
`define PCM_MODE_MULT       2'h3

// Divider terminal counts (cycles of base toggles minus one)
`define PCM_DIV_SIXT_LIM    5'h0f
`define PCM_DIV_SIXT_LEG    5'h1f
`define PCM_DIV_FULL_LEG    5'h01

// Multiplier: x5 means ten half periods per reference period
`define PCM_MULT_HALVES     16'h000a
`define PCM_MULT_NCO_TICKS  4'h9
`define PCM_RAMP_MAX        8'hff

`endif

/* src/pcm_mult.v */
// Phase-locked x5 multiplier model with bypass, power control and
// lock-ramp counter. Reference edges arrive as one-cycle pulses in
// the system clock domain; the output is a stream of toggle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "pcm_defines.vh"

module pcm_mult
#(
  parameter PER_W  = 16,
  parameter RAMP_W = 8
)
(
  // Clock, reset, enable
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // Control
  input  wire pwr,
  input  wire ref_rise,
  input  wire dev_rst_n,
  // Results
  output wire tick,
  output wire locked,
  output wire ramp_done
);

  reg  [PER_W-1:0]  cnt_ff;
  reg  [PER_W-1:0]  period_ff;
  reg  [PER_W-1:0]  hcnt_ff;
  reg  [3:0]        tcnt_ff;
  reg  [RAMP_W-1:0] ramp_ff;
  reg               ramp_done_ff;
  reg               locked_ff;
  reg               use_nco_ff;
  wire [PER_W-1:0]  half;
  wire [PER_W-1:0]  diff;
  wire              close;
  wire              nco_end;

  // Ten output half periods per reference period
  assign half    = period_ff / `PCM_MULT_HALVES;
  assign diff    = (cnt_ff > period_ff) ? (cnt_ff - period_ff)
                                        : (period_ff - cnt_ff);
  assign close   = (diff <= {{(PER_W-1){1'b0}}, 1'b1});
  // The tenth half period always ends on the reference edge itself
  assign nco_end = (hcnt_ff + 1'b1 >= half) &&
                   (tcnt_ff < `PCM_MULT_NCO_TICKS);
  assign tick      = pwr & (use_nco_ff ? (ref_rise | nco_end) : ref_rise);
  assign locked    = locked_ff;
  assign ramp_done = ramp_done_ff;

  // Period measure, acquisition and tracking
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff     <= {PER_W{1'b0}};
      period_ff  <= {PER_W{1'b0}};
      locked_ff  <= 1'b0;
      use_nco_ff <= 1'b0;
      hcnt_ff    <= {PER_W{1'b0}};
      tcnt_ff    <= 4'h0;
    end
    else if (ce)
    begin
      if (!pwr)
      begin
        cnt_ff     <= {PER_W{1'b0}};
        locked_ff  <= 1'b0;
        use_nco_ff <= 1'b0;
        hcnt_ff    <= {PER_W{1'b0}};
        tcnt_ff    <= 4'h0;
      end
      else if (ref_rise)
      begin
        period_ff  <= cnt_ff;
        locked_ff  <= close;
        cnt_ff     <= {{(PER_W-1){1'b0}}, 1'b1};
        // switch on a reference rising edge, or off when power drops, glitch-free
        use_nco_ff <= close && locked_ff && ramp_done_ff;
        hcnt_ff    <= {PER_W{1'b0}};
        tcnt_ff    <= 4'h0;
      end
      else
      begin
        if (cnt_ff != {PER_W{1'b1}})
          cnt_ff <= cnt_ff + 1'b1;
        if (nco_end)
        begin
          hcnt_ff <= {PER_W{1'b0}};
          tcnt_ff <= tcnt_ff + 4'h1;
        end
        else
          hcnt_ff <= hcnt_ff + 1'b1;
      end
    end
  end

  // ramp counter, halted while reset pin low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_ff      <= {RAMP_W{1'b0}};
      ramp_done_ff <= 1'b0;
    end
    else if (ce && pwr && ref_rise && dev_rst_n && !ramp_done_ff)
    begin
      // once done the count stays cleared for later resets
      ramp_ff <= ramp_ff + 1'b1;
      if (ramp_ff == {RAMP_W{1'b1}})
        ramp_done_ff <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* src/pcm_clock_mode_control.v */
// Clock mode control: mode pin decode, reference select, x5
// multiplier, CPU divider with stop and legacy halving, and an
// Avalon-MM register slave. Reference inputs are synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
`include "pcm_defines.vh"

module pcm_clock_mode_control
#(
  parameter PER_W  = 16,
  parameter RAMP_W = 8
)
(
  // Clock, reset, enable
  input  wire        CLK,
  input  wire        NRST,
  input  wire        CE,
  // Mode pins and reference sources
  input  wire        CLOCK_MODE_SELECT_LOW,
  input  wire        CLOCK_MODE_SELECT_HIGH,
  input  wire        EXTERNAL_REFERENCE_INPUT,
  input  wire        CRYSTAL_INPUT,
  output reg         CRYSTAL_DRIVE_OUTPUT,
  // Device reset and interrupt pins
  input  wire        RESET_PIN_N,
  input  wire        INTERRUPT_PIN_N,
  // Generated clocks and status
  output reg         PRIMARY_CLOCK_PHASE,
  output reg         SECONDARY_CLOCK_PHASE,
  output reg         MULTIPLIER_POWER,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [3:0]  AVS_BYTEENABLE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST
);

  reg  [1:0]  rst_sync_ff;
  wire        rst_n;
  reg         ref_ff;
  reg         dev_rst_ff;
  reg  [1:0]  div_ff;
  reg  [1:0]  nxt_div;
  reg         legacy_ff;
  reg  [4:0]  dcnt_ff;
  reg  [4:0]  lim;
  reg         base_tick;
  wire [1:0]  mode;
  wire        feedback;
  wire        mult_on;
  wire        ref_now;
  wire        ref_rise;
  wire        ref_fall;
  wire        rst_fall;
  wire        wake;
  wire        mult_tick;
  wire        locked;
  wire        ramp_done;
  wire        req;
  wire        acc;
  wire        wr_ctrl;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  assign mode     = {CLOCK_MODE_SELECT_HIGH, CLOCK_MODE_SELECT_LOW};
  assign feedback = (mode != `PCM_MODE_STATIC);
  // multiplier powered only in the x5 mode
  assign mult_on  = (mode == `PCM_MODE_MULT);

  // unused source is grounded, so XOR passes the live one
  assign ref_now  = EXTERNAL_REFERENCE_INPUT ^ CRYSTAL_INPUT;
  assign ref_rise = ref_now & ~ref_ff;
  assign ref_fall = ~ref_now & ref_ff;
  assign rst_fall = dev_rst_ff & ~RESET_PIN_N;
  assign wake     = ~RESET_PIN_N | ~INTERRUPT_PIN_N;

  // x5 multiplier with ramp and lock
  pcm_mult
  #(
    .PER_W  (PER_W),
    .RAMP_W (RAMP_W)
  )
  u_mult
  (
    .clk       (CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .pwr       (mult_on),
    .ref_rise  (ref_rise),
    .dev_rst_n (RESET_PIN_N),
    .tick      (mult_tick),
    .locked    (locked),
    .ramp_done (ramp_done)
  );

  // ratio per mode, as toggle events of the base clock
  always @*
  begin
    case (mode)
      `PCM_MODE_MULT: base_tick = mult_tick;
      `PCM_MODE_HALF: base_tick = ref_rise; // Rising edges only
      default:        base_tick = ref_rise | ref_fall;
    endcase
  end

  always @*
  begin
    if (div_ff == `PCM_DIV_SIXTEENTH)
      lim = legacy_ff ? `PCM_DIV_SIXT_LEG : `PCM_DIV_SIXT_LIM;
    else
      lim = legacy_ff ? `PCM_DIV_FULL_LEG : 5'h00;
  end

  // Bus handshake: one wait cycle, then a single accept cycle
  assign req     = AVS_READ | AVS_WRITE;
  assign acc     = req & ~AVS_WAITREQUEST;
  assign wr_ctrl = acc & AVS_WRITE & AVS_BYTEENABLE[0] &
                   (AVS_ADDRESS == `PCM_OFS_CTRL);

  // Divider setting; while stopped, hardware wake beats a same-cycle write
  always @*
  begin
    nxt_div = div_ff;
    if (wr_ctrl)
      nxt_div = AVS_WRITEDATA[`PCM_CTRL_DIV_HI:`PCM_CTRL_DIV_LO];
    if (nxt_div == 2'h3)
      nxt_div = div_ff;
    // leave stop on reset or interrupt low
    if (div_ff == `PCM_DIV_STOP && wake)
      nxt_div = `PCM_DIV_FULL;
    // reset fall forces a defined divider state
    if (rst_fall)
      nxt_div = `PCM_DIV_FULL;
  end

  // Control registers and edge history
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_ff     <= 1'b0;
      dev_rst_ff <= 1'b0;
      div_ff     <= `PCM_DIV_FULL;
      legacy_ff  <= 1'b0;
    end
    else if (CE)
    begin
      ref_ff     <= ref_now;
      dev_rst_ff <= RESET_PIN_N;
      div_ff     <= nxt_div;
      if (wr_ctrl)
        legacy_ff <= AVS_WRITEDATA[`PCM_CTRL_LEGACY];
    end
  end

  // Output clock phases from the divided base toggles
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dcnt_ff               <= 5'h00;
      PRIMARY_CLOCK_PHASE   <= 1'b0;
      SECONDARY_CLOCK_PHASE <= 1'b1;
    end
    else if (CE)
    begin
      // reset fall restarts the phase from present state
      if (rst_fall)
        dcnt_ff <= 5'h00;
      else if (base_tick && div_ff != `PCM_DIV_STOP)
      begin
        if (dcnt_ff >= lim)
        begin
          dcnt_ff               <= 5'h00;
          PRIMARY_CLOCK_PHASE   <= ~PRIMARY_CLOCK_PHASE;
          SECONDARY_CLOCK_PHASE <= PRIMARY_CLOCK_PHASE;
        end
        else
          dcnt_ff <= dcnt_ff + 5'h01;
      end
    end
  end

  // Oscillator drive: inverse of the crystal when feedback is on
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CRYSTAL_DRIVE_OUTPUT <= 1'b0;
      MULTIPLIER_POWER     <= 1'b0;
    end
    else if (CE)
    begin
      // feedback and power follow the mode pins
      CRYSTAL_DRIVE_OUTPUT <= feedback & ~CRYSTAL_INPUT;
      MULTIPLIER_POWER     <= mult_on;
    end
  end

  // Bus slave: read data loaded with the waitrequest drop
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end
    else if (CE)
    begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (req && AVS_WAITREQUEST)
      begin
        AVS_READDATA <= 32'h00000000;
        if (AVS_READ && AVS_ADDRESS == `PCM_OFS_CTRL)
        begin
          AVS_READDATA[`PCM_CTRL_DIV_HI:`PCM_CTRL_DIV_LO] <= div_ff;
          AVS_READDATA[`PCM_CTRL_LEGACY] <= legacy_ff;
        end
        else if (AVS_READ && AVS_ADDRESS == `PCM_OFS_STATUS)
        begin
          AVS_READDATA[`PCM_ST_LOCKED]    <= locked;
          AVS_READDATA[`PCM_ST_RAMP_DONE] <= ramp_done;
          AVS_READDATA[`PCM_ST_MODE_HI:`PCM_ST_MODE_LO] <= mode;
          AVS_READDATA[`PCM_ST_DIV_HI:`PCM_ST_DIV_LO]   <= div_ff;
          AVS_READDATA[`PCM_ST_STOPPED]  <= (div_ff == `PCM_DIV_STOP);
          AVS_READDATA[`PCM_ST_MULT_PWR] <= mult_on;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* test/pcm_cmc_properties.sv */
// Port-level checker for the clock mode control block.
// Assumes CE high and reference inputs synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module pcm_cmc_props
#(
  parameter PER_W  = 16,
  parameter RAMP_W = 8
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Mode and reference pins
  input wire logic CLOCK_MODE_SELECT_LOW,
  input wire logic CLOCK_MODE_SELECT_HIGH,
  input wire logic EXTERNAL_REFERENCE_INPUT,
  input wire logic CRYSTAL_INPUT,
  input wire logic CRYSTAL_DRIVE_OUTPUT,
  // Generated clocks
  input wire logic PRIMARY_CLOCK_PHASE,
  input wire logic SECONDARY_CLOCK_PHASE,
  input wire logic MULTIPLIER_POWER,
  // Bus handshake
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST
);
  wire logic [1:0] md = {CLOCK_MODE_SELECT_HIGH, CLOCK_MODE_SELECT_LOW};
  wire logic       rq = AVS_READ || AVS_WRITE;
  logic [5:0]      rh;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Reference history; six samples cover the edge-to-toggle latency
  always @(posedge CLK)
    rh <= {rh[4:0], EXTERNAL_REFERENCE_INPUT ^ CRYSTAL_INPUT};

  sequence s_one_wait;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  a_phase_inverse: assert property (
    SECONDARY_CLOCK_PHASE != PRIMARY_CLOCK_PHASE)
    else $error("phase outputs not complementary");
  a_mult_power: assert property (
    $stable(md)[*5] |-> MULTIPLIER_POWER == (md == 2'h3))
    else $error("multiplier power disagrees with mode");
  a_xtal_drive: assert property (
    (md != 2'h0)[*5] |-> CRYSTAL_DRIVE_OUTPUT == !$past(CRYSTAL_INPUT))
    else $error("oscillator drive not inverse of input");
  a_static_quiet: assert property (
    (md == 2'h0)[*5] |-> !CRYSTAL_DRIVE_OUTPUT)
    else $error("oscillator drive active in static mode");
  a_ref_driven: assert property (
    (md != 2'h3)[*8] ##0 $changed(PRIMARY_CLOCK_PHASE)
    |-> rh != 6'h00 && rh != 6'h3f)
    else $error("bypass toggle without reference edge");
  a_halfrate_rise: assert property (
    (md == 2'h2)[*8] ##0 $changed(PRIMARY_CLOCK_PHASE)
    |-> |(rh[4:0] & ~rh[5:1]))
    else $error("half ratio toggle not on rising edge");
  a_bus_one_wait: assert property (
    rq && AVS_WAITREQUEST |=> s_one_wait)
    else $error("bus answer not after one wait cycle");
  a_bus_idle_wait: assert property (
    !rq && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("bus answered without a request");
endmodule

bind pcm_clock_mode_control pcm_cmc_props
  #(.PER_W(PER_W), .RAMP_W(RAMP_W)) pcm_cmc_props_i (.*);
`default_nettype wire

/* test/pcm_xtal_model.sv */
// Reference source model: crystal or external clock, free running.
// Assumes a half period given in CLK cycles.
`timescale 1ns/10ps
`default_nettype none
module pcm_xtal_model
#(
  parameter HALF = 20
)
(
  // Timing and source choice
  input  wire logic clk,
  input  wire logic use_xtal,
  // Reference levels
  output var  logic crystal_input,
  output var  logic ext
);
  int   n = 0;
  logic lv = 1'b0;

  // Oscillator runs free, as a crystal does
  always @(posedge clk)
    if (n == HALF - 1)
    begin
      n  <= 0;
      lv <= !lv;
    end
    else
      n <= n + 1;

  always @*
  begin
    crystal_input = use_xtal & lv;
    ext = !use_xtal & lv;
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the clock mode control block.
// Assumes reference period of 40 CLK cycles from the source model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CLK = 0, NRST = 0, CE = 1, RESET_PIN_N = 1, INTERRUPT_PIN_N = 1;
  logic CLOCK_MODE_SELECT_LOW = 1, CLOCK_MODE_SELECT_HIGH = 1;
  logic AVS_READ = 0, AVS_WRITE = 0, use_xtal = 1, pp = 0;
  logic [3:0]  AVS_ADDRESS = 0, AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 0, rd;
  wire logic   EXTERNAL_REFERENCE_INPUT, CRYSTAL_INPUT, CRYSTAL_DRIVE_OUTPUT;
  wire logic   PRIMARY_CLOCK_PHASE, SECONDARY_CLOCK_PHASE, MULTIPLIER_POWER;
  wire logic   AVS_WAITREQUEST;
  wire logic [31:0] AVS_READDATA;
  int error_cnt = 0, checked = 0, tog = 0;

  pcm_clock_mode_control pcm_clock_mode_control_i (.*);
  pcm_xtal_model #(.HALF(20)) pcm_xtal_model_i (.clk(CLK),
    .use_xtal(use_xtal), .crystal_input(CRYSTAL_INPUT), .ext(EXTERNAL_REFERENCE_INPUT));

  always #2.5 CLK = !CLK;

  // Count primary phase toggles
  always @(posedge CLK)
  begin
    pp <= PRIMARY_CLOCK_PHASE;
    if (pp !== PRIMARY_CLOCK_PHASE)
      tog <= tog + 1;
  end

  task end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    i = 0;
    do
    begin
      @(posedge CLK);
      i++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && i < 50);
    if (i >= 50)
    begin
      error_cnt++;
      end_of_test;
    end
    rd = AVS_READDATA;
    AVS_READ <= 0;
    AVS_WRITE <= 0;
  endtask

  // Toggles in a window that spans whole output periods
  task meas(input int win, input int exp);
    int t0;
    repeat (400) @(posedge CLK);
    t0 = tog;
    repeat (win) @(posedge CLK);
    chk(tog - t0, exp);
  endtask

  task mode(input logic l, input logic h, input int e);
    CLOCK_MODE_SELECT_LOW <= l;
    CLOCK_MODE_SELECT_HIGH <= h;
    meas(160, e);
  endtask

  task pin_pulse;
    RESET_PIN_N <= 0;
    repeat (4) @(posedge CLK);
    RESET_PIN_N <= 1;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge CLK);
    chk({PRIMARY_CLOCK_PHASE, SECONDARY_CLOCK_PHASE, MULTIPLIER_POWER,
      AVS_WAITREQUEST, CRYSTAL_DRIVE_OUTPUT}, 5'h0a);
    NRST <= 1;
    repeat (3) @(posedge CLK);
    meas(160, 4);
    bus(0, 4'h4, 0);
    chk(rd & 32'h8e, 32'h8c);
    repeat (11000) @(posedge CLK);
    meas(160, 40);
    bus(0, 4'h4, 0);
    chk(rd & 32'hff, 32'h8f);
    pin_pulse;
    meas(160, 40);
    use_xtal <= 0;
    mode(0, 0, 8);
    chk({CRYSTAL_DRIVE_OUTPUT, MULTIPLIER_POWER}, 2'h0);
    mode(0, 1, 4);
    chk(CRYSTAL_DRIVE_OUTPUT, 1);
    mode(1, 0, 8);
    bus(1, 4'h0, 1);
    meas(640, 2);
    bus(1, 4'h0, 4);
    meas(160, 4);
    bus(1, 4'h0, 2);
    meas(160, 0);
    bus(0, 4'h4, 0);
    chk(rd & 32'h70, 32'h60);
    INTERRUPT_PIN_N <= 0;
    repeat (2) @(posedge CLK);
    INTERRUPT_PIN_N <= 1;
    meas(160, 8);
    bus(1, 4'h0, 2);
    meas(160, 0);
    pin_pulse;
    meas(160, 8);
    bus(1, 4'h0, 1);
    pin_pulse;
    meas(160, 8);
    bus(1, 4'h0, 3);
    bus(0, 4'h0, 0);
    chk(rd & 32'h7, 32'h0);
    bus(0, 4'h8, 0);
    chk(rd, 0);
    end_of_test;
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge CLK);
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
